// File: rtl/ddrm_consts.svh
// Timing counts, field positions and reset values shared by both ends of the module link
`ifndef DDRM_CONSTS_SVH
`define DDRM_CONSTS_SVH
`define DDRM_CLK_MHZ 100
`define DDRM_CK_DIV 4
`define DDRM_TRCD_CK 3
`define DDRM_TRP_CK 3
`define DDRM_CL_CK 3
`define DDRM_A10_BIT 10
`define DDRM_ROW_W 13
`define DDRM_COL_W 11
`define DDRM_MEM_DEPTH 256
`define DDRM_MEM_AW 8
`define DDRM_BL_RESET 4'h4
`define DDRM_PD_RESET 3'h0
`define DDRM_SCL_DIV 16
`endif

// File: rtl/ddrm_pkg.sv
// Types shared by the memory end and the controller end
package ddrm_pkg;
    typedef enum logic [2:0] {
        DDRM_CMD_NOP = 3'h7,
        DDRM_CMD_ACT = 3'h3,
        DDRM_CMD_RD = 3'h5,
        DDRM_CMD_WR = 3'h4,
        DDRM_CMD_PRE = 3'h2,
        DDRM_CMD_REF = 3'h1,
        DDRM_CMD_MRS = 3'h0,
        DDRM_CMD_BST = 3'h6
    } ddrm_cmd_t;
    typedef logic [71:0] ddrm_word_t;
    typedef logic [8:0] ddrm_mask_t;
endpackage

// File: rtl/ddrm_if.sv
// Pin-level link between the memory controller and the memory module
`timescale 1ns/1ns
interface ddrm_if;
    logic ck;
    logic cke;
    logic sel_n;
    logic [2:0] cmd;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [8:0] dm;
    logic [71:0] dq_c_o;
    logic dq_c_oe;
    logic [71:0] dq_m_o;
    logic dq_m_oe;
    logic dqs_c_o;
    logic dqs_c_oe;
    logic dqs_m_o;
    logic dqs_m_oe;
    logic scl;
    logic sda_c_o;
    logic sda_c_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic [2:0] pd_straps;
    // Resolved shared wires
    wire [71:0] dq = dq_m_oe ? dq_m_o : (dq_c_oe ? dq_c_o : 72'h0);
    wire dqs = dq_m_oe ? dqs_m_o : (dqs_c_oe ? dqs_c_o : 1'b0);
    wire sda = !((sda_c_oe && !sda_c_o) || (sda_m_oe && !sda_m_o));
    modport mem (input ck, cke, sel_n, cmd, ba, addr, dm, dq, dqs, scl, sda, pd_straps,
        output dq_m_o, dq_m_oe, dqs_m_o, dqs_m_oe, sda_m_o, sda_m_oe);
    modport ctl (input dq, dqs, sda,
        output ck, cke, sel_n, cmd, ba, addr, dm, dq_c_o, dq_c_oe, dqs_c_o, dqs_c_oe, scl, sda_c_o, sda_c_oe,
        pd_straps);
endinterface

// File: rtl/ddrm_sync.sv
// Two-flop synchroniser with edge flags taken from the second stage onward
`timescale 1ns/1ns
module ddrm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Async in, synced out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign q = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule // ddrm_sync

// File: rtl/ddrm_mem.sv
// Memory module end: command decoder, four banks, burst engine and presence-detect slave
`timescale 1ns/1ns
`include "ddrm_consts.svh"
module ddrm_mem (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link
    ddrm_if.mem lnk,
    // Status
    output logic [3:0] bank_open,
    output logic pwr_down,
    output logic [15:0] refresh_count
);
    import ddrm_pkg::*;
    logic ck_s, ck_r, dqs_s, dqs_r, dqs_f, scl_s, scl_r, scl_f, sda_s, sda_r, sda_f;
    logic cke_s, sel_s;
    logic [2:0] cmd_s;
    logic [1:0] ba_s;
    logic [12:0] addr_s;
    logic [8:0] dm_s;
    logic [71:0] dq_s;
    logic [2:0] pa_s;
    // Every link input is from another domain, so it is synchronised first
    ddrm_sync #(.W(1)) u_ck (.clk_sys(clk_sys), .rst_n(rst_n), .d(lnk.ck), .q(ck_s), .rise(ck_r), .fall());
    ddrm_sync #(.W(1)) u_dqs (.clk_sys(clk_sys), .rst_n(rst_n), .d(lnk.dqs), .q(dqs_s), .rise(dqs_r), .fall(dqs_f));
    ddrm_sync #(.W(1)) u_scl (.clk_sys(clk_sys), .rst_n(rst_n), .d(lnk.scl), .q(scl_s), .rise(scl_r), .fall(scl_f));
    ddrm_sync #(.W(1)) u_sda (.clk_sys(clk_sys), .rst_n(rst_n), .d(lnk.sda), .q(sda_s), .rise(sda_r), .fall(sda_f));
    ddrm_sync #(.W(104)) u_bus (.clk_sys(clk_sys), .rst_n(rst_n),
        .d({lnk.cke, lnk.sel_n, lnk.cmd, lnk.ba, lnk.addr, lnk.dm, lnk.dq, lnk.pd_straps}),
        .q({cke_s, sel_s, cmd_s, ba_s, addr_s, dm_s, dq_s, pa_s}), .rise(), .fall());

    // Array: one word per bank/row/column slice, row and column folded into a small index
    logic [71:0] mem_q [0:`DDRM_MEM_DEPTH-1];
    logic [12:0] row_q [0:3];
    logic [3:0] open_q;
    logic [3:0] bl_q;
    logic pd_q;
    logic [15:0] rfc_q;
    logic busy_q, wr_q, ap_q;
    logic [1:0] bbank_q;
    logic [10:0] col_q;
    logic [3:0] left_q;
    logic [1:0] lat_q;
    logic dq_oe_q, dqs_oe_q, dqs_o_q;
    logic [71:0] dq_o_q;
    logic [3:0] wrap_m;
    logic [7:0] idx;
    // Valid command only when selected and clocked; positive link clock edge
    wire cmd_ok = ck_r && cke_s && !sel_s;
    assign wrap_m = bl_q - 4'h1;
    assign idx = {bbank_q, row_q[bbank_q][2:0], col_q[2:0]};
    // Burst moves one location: a strobe edge on writes, a link clock edge on reads
    // The last read location never meets a link clock rise, so the row close keys on these
    wire wr_step = dqs_r || dqs_f;
    wire rd_step = lat_q == 2'h3 && (ck_r || (dqs_oe_q && !ck_s && dqs_o_q));

    // Bank state; each bank opens and closes on its own, except a precharge with A10 set closes all four
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            open_q <= 4'h0;
            for (int i = 0; i < 4; i++) row_q[i] <= 13'h0;
        end else begin
            if (cmd_ok && ddrm_cmd_t'(cmd_s) == DDRM_CMD_ACT) begin
                open_q[ba_s] <= 1'b1;
                row_q[ba_s] <= addr_s;
            end
            if (cmd_ok && ddrm_cmd_t'(cmd_s) == DDRM_CMD_PRE) begin
                if (addr_s[`DDRM_A10_BIT]) open_q <= 4'h0;
                else open_q[ba_s] <= 1'b0;
            end
            if (busy_q && left_q == 4'h1 && ap_q && (wr_q ? wr_step : rd_step)) open_q[bbank_q] <= 1'b0;
        end
    end

    // Mode register: burst length from low address bits; refresh counter; power-down
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bl_q <= `DDRM_BL_RESET;
            pd_q <= 1'b0;
            rfc_q <= 16'h0;
        end else begin
            if (cmd_ok && ddrm_cmd_t'(cmd_s) == DDRM_CMD_MRS && ba_s == 2'h0) begin
                case (addr_s[2:0])
                    3'h1: bl_q <= 4'h2;
                    3'h2: bl_q <= 4'h4;
                    3'h3: bl_q <= 4'h8;
                    default: bl_q <= bl_q; // Reserved codes keep the old length
                endcase
            end
            if (cmd_ok && ddrm_cmd_t'(cmd_s) == DDRM_CMD_REF && open_q == 4'h0) rfc_q <= rfc_q + 16'h1;
            if (ck_r) pd_q <= !cke_s;
        end
    end

    // Burst engine; a new read/write only while idle, bank must be open (checked here against open_q)
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            ap_q <= 1'b0;
            bbank_q <= 2'h0;
            col_q <= 11'h0;
            left_q <= 4'h0;
            lat_q <= 2'h0;
        end else if (!busy_q) begin
            if (cmd_ok && (ddrm_cmd_t'(cmd_s) == DDRM_CMD_RD || ddrm_cmd_t'(cmd_s) == DDRM_CMD_WR)
                && open_q[ba_s]) begin
                busy_q <= 1'b1;
                wr_q <= ddrm_cmd_t'(cmd_s) == DDRM_CMD_WR;
                ap_q <= addr_s[`DDRM_A10_BIT];
                bbank_q <= ba_s;
                col_q <= {addr_s[11], addr_s[9:0]};
                left_q <= bl_q;
                lat_q <= 2'h0;
            end
        end else if (wr_q) begin
            // Each strobe edge stores one word, low bits wrap in the block
            if (dqs_r || dqs_f) begin
                col_q <= {col_q[10:3], (col_q[2:0] & ~wrap_m[2:0]) | ((col_q[2:0] + 3'h1) & wrap_m[2:0])};
                left_q <= left_q - 4'h1;
                if (left_q == 4'h1) busy_q <= 1'b0;
            end
        end else if (ck_r && lat_q != 2'h3) begin
            lat_q <= lat_q + 2'h1;
        end else if (lat_q == 2'h3 && (ck_r || (dqs_oe_q && !ck_s && dqs_o_q))) begin
            col_q <= {col_q[10:3], (col_q[2:0] & ~wrap_m[2:0]) | ((col_q[2:0] + 3'h1) & wrap_m[2:0])};
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) busy_q <= 1'b0;
        end
    end

    // Write storage with per-byte mask; read path does not look at the mask
    always_ff @(posedge clk_sys) begin
        if (busy_q && wr_q && (dqs_r || dqs_f)) begin
            for (int b = 0; b < 9; b++)
                if (!dm_s[b]) mem_q[idx][b*8 +: 8] <= dq_s[b*8 +: 8];
        end
    end

    // Read drivers: word and strobe flip together so the strobe is edge-aligned
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dq_oe_q <= 1'b0;
            dqs_oe_q <= 1'b0;
            dqs_o_q <= 1'b0;
            dq_o_q <= 72'h0;
        end else if (busy_q && !wr_q && lat_q == 2'h3 && (ck_r || (dqs_oe_q && !ck_s && dqs_o_q))) begin
            dq_oe_q <= 1'b1;
            dqs_oe_q <= 1'b1;
            dqs_o_q <= ck_r;
            dq_o_q <= mem_q[idx];
        end else if (!busy_q || wr_q) begin
            dq_oe_q <= 1'b0;
            dqs_oe_q <= 1'b0;
            dqs_o_q <= 1'b0;
        end
    end
    assign lnk.dq_m_o = dq_o_q;
    assign lnk.dq_m_oe = dq_oe_q;
    assign lnk.dqs_m_o = dqs_o_q;
    assign lnk.dqs_m_oe = dqs_oe_q;

    // Presence-detect slave: address match against straps, acks and returns bank state byte
    logic [3:0] pbit_q;
    logic [7:0] psh_q;
    logic pact_q, pack_q, prd_q, pmatch_q, sda_oe_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pbit_q <= 4'h0;
            psh_q <= 8'h0;
            pact_q <= 1'b0;
            pack_q <= 1'b0;
            prd_q <= 1'b0;
            pmatch_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (scl_s && sda_f) begin
            pact_q <= 1'b1;
            pbit_q <= 4'h0;
            pmatch_q <= 1'b0;
            prd_q <= 1'b0;
        end else if (scl_s && sda_r) begin
            pact_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (pact_q && scl_r && pbit_q != 4'h8) begin
            psh_q <= {psh_q[6:0], sda_s};
            pbit_q <= pbit_q + 4'h1;
        end else if (pact_q && scl_f) begin
            if (pbit_q == 4'h8 && !pack_q) begin
                pack_q <= 1'b1;
                if (!pmatch_q && psh_q[7:1] == {4'ha, pa_s}) begin
                    pmatch_q <= 1'b1;
                    prd_q <= psh_q[0];
                    sda_oe_q <= 1'b1;
                end else sda_oe_q <= pmatch_q && !prd_q;
            end else if (pack_q) begin
                pack_q <= 1'b0;
                pbit_q <= 4'h0;
                psh_q <= {4'h0, open_q};
                sda_oe_q <= prd_q && !open_q[3];
            end else if (prd_q && pmatch_q) begin
                psh_q <= {psh_q[6:0], 1'b0};
                sda_oe_q <= !psh_q[6];
            end else sda_oe_q <= 1'b0;
        end
    end
    assign lnk.sda_m_o = 1'b0;
    assign lnk.sda_m_oe = sda_oe_q;

    // Status outputs registered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_open <= 4'h0;
            pwr_down <= `DDRM_PD_RESET == 3'h1;
            refresh_count <= 16'h0;
        end else begin
            bank_open <= open_q;
            pwr_down <= pd_q;
            refresh_count <= rfc_q;
        end
    end
endmodule // ddrm_mem

// File: rtl/ddrm_ctl.sv
// Controller end: makes the link clock, issues commands, drives write data, sets presence-detect straps
`timescale 1ns/1ns
`include "ddrm_consts.svh"
module ddrm_ctl (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link
    ddrm_if.ctl lnk,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_bank,
    input wire logic [12:0] req_row,
    input wire logic [10:0] req_col,
    input wire logic req_auto_pre,
    input wire logic [71:0] req_wdata,
    input wire logic [8:0] req_mask,
    input wire logic [2:0] pd_addr,
    // User answer
    output logic req_ready,
    output logic rd_valid,
    output logic [71:0] rd_data
);
    import ddrm_pkg::*;
    typedef enum logic [2:0] {DDRM_S_IDLE, DDRM_S_ACT, DDRM_S_WAIT, DDRM_S_CMD, DDRM_S_DATA} ddrm_st_t;
    ddrm_st_t st_q;
    logic [1:0] div_q;
    logic ck_q, pos_en, neg_en;
    logic [2:0] wait_q;
    logic [3:0] beat_q;
    logic [2:0] cmd_q;
    logic [1:0] ba_q;
    logic [12:0] addr_q;
    logic dqs_oe_q, dqs_o_q, dq_oe_q;
    logic dqs_s, dqs_r, dqs_f;
    logic [71:0] dq_s;
    ddrm_sync #(.W(1)) u_dqs (.clk_sys(clk_sys), .rst_n(rst_n), .d(lnk.dqs), .q(dqs_s), .rise(dqs_r), .fall(dqs_f));
    ddrm_sync #(.W(72)) u_dq (.clk_sys(clk_sys), .rst_n(rst_n), .d(lnk.dq), .q(dq_s), .rise(), .fall());
    // Link clock divider; commands change on the falling half so they are stable at the rise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 2'h0;
            ck_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h1) ck_q <= 1'b1;
            if (div_q == 2'h3) ck_q <= 1'b0;
        end
    end
    assign pos_en = div_q == 2'h3;
    assign neg_en = div_q == 2'h1;
    // Command sequencer: ACTIVE, wait, then READ/WRITE; clock enable held high throughout
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= DDRM_S_IDLE;
            cmd_q <= 3'h7;
            ba_q <= 2'h0;
            addr_q <= 13'h0;
            wait_q <= 3'h0;
            beat_q <= 4'h0;
            req_ready <= 1'b0;
        end else if (pos_en) begin
            cmd_q <= 3'h7;
            case (st_q)
                DDRM_S_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        st_q <= DDRM_S_ACT;
                    end
                end
                DDRM_S_ACT: begin
                    cmd_q <= 3'h3;
                    ba_q <= req_bank;
                    addr_q <= req_row;
                    wait_q <= 3'(`DDRM_TRCD_CK);
                    st_q <= DDRM_S_WAIT;
                end
                DDRM_S_WAIT: begin
                    wait_q <= wait_q - 3'h1;
                    if (wait_q == 3'h2) st_q <= DDRM_S_CMD;
                end
                DDRM_S_CMD: begin
                    cmd_q <= req_write ? 3'h4 : 3'h5;
                    addr_q <= {1'b0, req_col[10], req_auto_pre, req_col[9:0]};
                    beat_q <= 4'h0;
                    st_q <= DDRM_S_DATA;
                end
                DDRM_S_DATA: begin
                    beat_q <= beat_q + 4'h1;
                    if (beat_q == 4'h9) begin
                        if (!req_auto_pre) begin
                            cmd_q <= 3'h2;
                            addr_q <= 13'h0;
                        end
                        st_q <= DDRM_S_IDLE;
                    end
                end
                default: st_q <= DDRM_S_IDLE;
            endcase
        end
    end
    // Write strobe: driven only in write burst, toggled mid-word for centre alignment
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dqs_oe_q <= 1'b0;
            dqs_o_q <= 1'b0;
            dq_oe_q <= 1'b0;
        end else begin
            dq_oe_q <= st_q == DDRM_S_DATA && req_write && beat_q > 4'h0 && beat_q < 4'h4;
            dqs_oe_q <= st_q == DDRM_S_DATA && req_write && beat_q > 4'h0 && beat_q < 4'h4;
            if (dq_oe_q && (pos_en || neg_en)) dqs_o_q <= !dqs_o_q;
            else if (!dq_oe_q) dqs_o_q <= 1'b0;
        end
    end
    // Read return: one word per strobe edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data <= 72'h0;
        end else begin
            rd_valid <= !req_write && (dqs_r || dqs_f);
            rd_data <= dq_s;
        end
    end
    assign lnk.ck = ck_q;
    assign lnk.cke = 1'b1;
    assign lnk.sel_n = cmd_q == 3'h7;
    assign lnk.cmd = cmd_q;
    assign lnk.ba = ba_q;
    assign lnk.addr = addr_q;
    assign lnk.dm = req_mask;
    assign lnk.dq_c_o = req_wdata;
    assign lnk.dq_c_oe = dq_oe_q;
    assign lnk.dqs_c_o = dqs_o_q;
    assign lnk.dqs_c_oe = dqs_oe_q;
    assign lnk.scl = 1'b1; // presence-detect bus idle; clocked by a separate master when used
    assign lnk.sda_c_o = 1'b1;
    assign lnk.sda_c_oe = 1'b0;
    assign lnk.pd_straps = pd_addr;
endmodule // ddrm_ctl

// File: dv/ddrm_sva.sv
// Checker watching the link between the controller end and the memory end
`timescale 1ns/1ns
module ddrm_sva
    import ddrm_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command side of the link
    input wire logic ck,
    input wire logic cke,
    input wire logic sel_n,
    input wire logic [2:0] cmd,
    input wire logic [1:0] ba,
    // Data side of the link
    input wire logic [71:0] dq_c_o,
    input wire logic dq_c_oe,
    input wire logic [71:0] dq_m_o,
    input wire logic dq_m_oe,
    input wire logic dqs_c_o,
    input wire logic dqs_c_oe,
    input wire logic dqs_m_o,
    input wire logic dqs_m_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic ck_q;
    logic [7:0] act_age_q [4];
    logic cmd_hit;
    // A command counts only at a link rising edge with the rank selected
    assign cmd_hit = ck && !ck_q && cke && !sel_n;
    // Cycles since each bank was opened; zero means never opened
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ck_q <= 1'b0;
            for (int b = 0; b < 4; b++) act_age_q[b] <= 8'h00;
        end else begin
            ck_q <= ck;
            for (int b = 0; b < 4; b++) begin
                if (cmd_hit && cmd == DDRM_CMD_ACT && ba == 2'(b)) act_age_q[b] <= 8'h01;
                else if (act_age_q[b] != 8'h00 && act_age_q[b] != 8'hff) act_age_q[b] <= act_age_q[b] + 8'h01;
            end
        end
    end
    dq_owner_a: assert property (!(dq_m_oe && dq_c_oe))
        else $error("both ends drive the data bus");
    dqs_owner_a: assert property (!(dqs_m_oe && dqs_c_oe))
        else $error("both ends drive the strobe");
    cke_access_a: assert property ((dq_m_oe || dq_c_oe) |-> cke)
        else $error("clock enable low during a data transfer");
    ck_period_a: assert property ($rose(ck) |-> ##4 $rose(ck))
        else $error("link clock period is not four system clocks");
    act_first_a: assert property (cmd_hit && (cmd == DDRM_CMD_RD || cmd == DDRM_CMD_WR) |-> act_age_q[ba] >= 8'h0c)
        else $error("column command too soon after row open");
    rd_answer_a: assert property (cmd_hit && cmd == DDRM_CMD_RD |-> ##[4:40] dqs_m_oe)
        else $error("no read strobe after a read command");
    rd_edge_a: assert property (dq_m_oe && $past(dq_m_oe) && $changed(dq_m_o) |-> $changed(dqs_m_o))
        else $error("read data moved without a strobe edge");
    wr_centre_a: assert property (dq_c_oe && $past(dq_c_oe) && $changed(dq_c_o) |-> $stable(dqs_c_o))
        else $error("write data moved on a strobe edge");
    act_seen_c: cover property (cmd_hit && cmd == DDRM_CMD_ACT);
    rd_seen_c: cover property (cmd_hit && cmd == DDRM_CMD_RD);
    wr_seen_c: cover property (cmd_hit && cmd == DDRM_CMD_WR);
    wr_strobe_c: cover property (dqs_c_oe && $changed(dqs_c_o));
    pre_seen_c: cover property (cmd_hit && cmd == DDRM_CMD_PRE);
endmodule // ddrm_sva

// File: dv/tb_top.sv
// Bench joining the controller end and the memory end across the link interface
`timescale 1ns/1ns
module tb_top;
    import ddrm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_bank = 2'h0;
    logic [12:0] req_row = 13'h0000;
    logic [10:0] req_col = 11'h000;
    logic req_auto_pre = 1'b1;
    ddrm_word_t req_wdata = '0;
    ddrm_mask_t req_mask = '0;
    logic [2:0] pd_addr = 3'h0;
    logic req_ready;
    logic rd_valid;
    ddrm_word_t rd_data;
    logic [3:0] bank_open;
    logic pwr_down;
    logic [15:0] refresh_count;
    int fails = 0;
    int check_count = 0;
    logic ck_q = 1'b0;
    ddrm_word_t mem_m [bit [7:0]];
    ddrm_word_t rd_q [$];
    logic [14:0] act_q [$];

    always #5 clk_sys = ~clk_sys;

    ddrm_if i_ddrm_if ();
    ddrm_mem i_ddrm_mem (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(i_ddrm_if), .bank_open(bank_open),
        .pwr_down(pwr_down), .refresh_count(refresh_count));
    ddrm_ctl i_ddrm_ctl (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(i_ddrm_if), .req_valid(req_valid),
        .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
        .req_auto_pre(req_auto_pre), .req_wdata(req_wdata), .req_mask(req_mask), .pd_addr(pd_addr),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));
    ddrm_sva i_ddrm_sva (.clk_sys(clk_sys), .rst_n(rst_n), .ck(i_ddrm_if.ck), .cke(i_ddrm_if.cke),
        .sel_n(i_ddrm_if.sel_n), .cmd(i_ddrm_if.cmd), .ba(i_ddrm_if.ba), .dq_c_o(i_ddrm_if.dq_c_o),
        .dq_c_oe(i_ddrm_if.dq_c_oe), .dq_m_o(i_ddrm_if.dq_m_o), .dq_m_oe(i_ddrm_if.dq_m_oe),
        .dqs_c_o(i_ddrm_if.dqs_c_o), .dqs_c_oe(i_ddrm_if.dqs_c_oe), .dqs_m_o(i_ddrm_if.dqs_m_o),
        .dqs_m_oe(i_ddrm_if.dqs_m_oe));

    // Compare one value and count the result
    task automatic check(string what, ddrm_word_t exp, ddrm_word_t got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single place where the run ends
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Wait for the ready level, bounded; a hang counts as a mismatch
    task automatic wait_ready(logic lvl);
        int n;
        n = 0;
        while (req_ready !== lvl && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 400) begin
            check("req_ready", 72'(lvl), 72'(req_ready));
            test_done();
        end
    endtask

    // One burst request; the bank model and the expected read words are noted first
    task automatic access(logic wr, logic [1:0] b, logic [12:0] r, logic [10:0] c, ddrm_word_t d, ddrm_mask_t m);
        logic [7:0] idx;
        wait_ready(1'b1);
        @(negedge clk_sys);
        req_write = wr;
        req_bank = b;
        req_row = r;
        req_col = c;
        req_wdata = d;
        req_mask = m;
        req_valid = 1'b1;
        act_q.push_back({b, r});
        // Burst of four wraps inside its aligned column block
        for (int k = 0; k < 4; k++) begin
            idx = {b, r[2:0], c[2], c[1:0] + 2'(k)};
            if (!wr) rd_q.push_back(mem_m[idx]);
            else for (int j = 0; j < 9; j++) if (!m[j]) mem_m[idx][8*j +: 8] = d[8*j +: 8];
        end
        // Request is held until ready has dropped and come back
        wait_ready(1'b0);
        wait_ready(1'b1);
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask

    // Watch read results and the command wires; the falling edge sees settled outputs
    always @(negedge clk_sys) begin
        ck_q <= i_ddrm_if.ck;
        if (rd_valid === 1'b1) begin
            if (rd_q.size() == 0) check("spare read word", 72'h0, 72'h1);
            else check("read data", rd_q.pop_front(), rd_data);
        end
        if (i_ddrm_if.ck && !ck_q && i_ddrm_if.cke && !i_ddrm_if.sel_n) begin
            if (i_ddrm_if.cmd == DDRM_CMD_ACT && act_q.size() > 0)
                check("open bank and row", 72'(act_q.pop_front()), 72'({i_ddrm_if.ba, i_ddrm_if.addr}));
            if (i_ddrm_if.cmd == DDRM_CMD_RD || i_ddrm_if.cmd == DDRM_CMD_WR)
                check("auto precharge bit", 72'(req_auto_pre), 72'(i_ddrm_if.addr[10]));
        end
    end

    // Main sequence
    initial begin
        logic [12:0] rows [4];
        logic [10:0] cols [4];
        int n;
        n = $urandom(32'hde97);
        pd_addr = 3'($urandom());
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        // Unmasked writes to every bank fill each burst block
        for (int i = 0; i < 4; i++) begin
            rows[i] = 13'($urandom());
            cols[i] = 11'($urandom());
            access(1'b1, 2'(i), rows[i], cols[i], 72'({$urandom(), $urandom(), $urandom()}), 9'h000);
        end
        // Partly masked overwrite of two banks keeps the masked bytes
        for (int i = 1; i < 3; i++)
            access(1'b1, 2'(i), rows[i], cols[i], 72'({$urandom(), $urandom(), $urandom()}), 9'($urandom()));
        // Back-to-back reads across all four banks; the last one closes its bank by a plain precharge
        for (int i = 3; i >= 0; i--) begin
            req_auto_pre = 1'(i != 0);
            access(1'b0, 2'(i), rows[i], cols[i], '0, 9'h000);
        end
        n = 0;
        while (rd_q.size() > 0 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        check("words still owed", 72'h0, 72'(rd_q.size()));
        repeat (40) @(posedge clk_sys);
        #1;
        check("banks left open", 72'h0, 72'(bank_open));
        check("power down", 72'h0, 72'(pwr_down));
        check("presence straps", 72'(pd_addr), 72'(i_ddrm_if.pd_straps));
        test_done();
    end
endmodule // tb_top
